// File: logic/asp_pkg.sv
/*
 * Constants for the security password command block: opcodes, status and
 * error bit positions, sector layout and password geometry.
 * Assumes a host command port that presents one opcode per strobe and
 * streams sector data one 16-bit word per beat.
 */
package asp_pkg;
    localparam logic [7:0] OP_DISABLE_PW = 8'hf6;
    localparam logic [7:0] OP_ERASE_ARM = 8'hf3;
    localparam logic [7:0] OP_ERASE_UNIT = 8'hf4;
    localparam int WORDS_PER_SECTOR = 256;
    localparam logic [7:0] LAST_WORD = 8'hff;
    localparam logic [7:0] PW_FIRST_WORD = 8'h01;
    localparam logic [7:0] PW_LAST_WORD = 8'h10;
    localparam int PW_WORDS = 16;
    localparam int CTRL_SEL_BIT = 0;
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_ABRT = 2;
    localparam logic [7:0] STATUS_RESET = 8'h40;
    localparam logic [7:0] ERROR_RESET = 8'h00;
endpackage : asp_pkg

// File: logic/asp_pw_if.sv
/*
 * Carrier between the command block and its password store.
 * Assumes one clock shared by both ends.
 */
interface asp_pw_if;
    logic wr_en;
    logic [3:0] wr_addr;
    logic [15:0] wr_data;
    logic rd_sel;
    logic [3:0] rd_addr;
    logic [15:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_sel,
        output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_sel,
        input rd_addr, output rd_data);
endinterface : asp_pw_if

// File: logic/asp_pw_store.sv
/*
 * Received-password buffer with registered read of the selected stored word.
 * Assumes stored user and master passwords arrive as flat 256-bit vectors.
 */
module asp_pw_store (
    input wire logic core_clk,
    input wire logic rst,
    asp_pw_if.store pw,
    input wire logic [255:0] user_pw,
    input wire logic [255:0] master_pw,
    output logic [15:0] rx_word
);
    logic [15:0] rx_mem [asp_pkg::PW_WORDS];

    always_ff @(posedge core_clk) begin
        if (pw.wr_en) begin
            rx_mem[pw.wr_addr] <= pw.wr_data;
        end
    end

    // Stored word and received word both registered so the compare lines up
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pw.rd_data <= 16'h0000;
            rx_word <= 16'h0000;
        end else begin
            pw.rd_data <= pw.rd_sel ? master_pw[{pw.rd_addr, 4'h0} +: 16]
                                    : user_pw[{pw.rd_addr, 4'h0} +: 16];
            rx_word <= rx_mem[pw.rd_addr];
        end
    end
endmodule : asp_pw_store

// File: logic/asp_cmd.sv
/*
 * Security password command interpreter: lock-disable with one sector of
 * password data, and erase arming checked by the following erase-unit.
 * Assumes the host obeys status: writes data only while drq is high,
 * issues commands only while bsy is low.
 */
module asp_cmd (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic data_valid,
    input wire logic [15:0] data_word,
    input wire logic [255:0] user_pw,
    input wire logic [255:0] master_pw,
    input wire logic security_on,
    output logic [7:0] status,
    output logic [7:0] error,
    output logic cmd_done,
    output logic lock_off,
    output logic erase_go
);
    typedef enum logic [2:0] {ASP_IDLE, ASP_XFER, ASP_CMP, ASP_DONE} asp_state_t;
    asp_state_t state;
    logic [7:0] word_idx;
    logic sel_master;
    logic [3:0] cmp_idx;
    logic cmp_live;
    logic [4:0] cmp_cnt;
    logic mismatch;
    logic armed;
    logic [15:0] rx_word;
    logic fail;

    asp_pw_if pw();

    asp_pw_store asp_pw_store_inst (
        .core_clk(core_clk),
        .rst(rst),
        .pw(pw.store),
        .user_pw(user_pw),
        .master_pw(master_pw),
        .rx_word(rx_word)
    );

    function automatic logic is_pw_word(input logic [7:0] idx);
        is_pw_word = (idx >= asp_pkg::PW_FIRST_WORD) && (idx <= asp_pkg::PW_LAST_WORD);
    endfunction : is_pw_word

    // Password words land in the buffer; reserved words are dropped
    assign pw.wr_en = (state == ASP_XFER) && data_valid && is_pw_word(word_idx);
    assign pw.wr_addr = 4'(word_idx - asp_pkg::PW_FIRST_WORD);
    assign pw.wr_data = data_word;
    assign pw.rd_sel = sel_master;
    assign pw.rd_addr = cmp_idx;
    assign fail = mismatch || (cmp_live && (rx_word != pw.rd_data));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= ASP_IDLE;
        end else begin
            unique case (state)
                ASP_IDLE: begin
                    if (cmd_valid && cmd_code == asp_pkg::OP_DISABLE_PW) begin
                        state <= ASP_XFER;
                    end else if (cmd_valid) begin
                        state <= ASP_DONE;
                    end
                end
                ASP_XFER: begin
                    if (data_valid && word_idx == asp_pkg::LAST_WORD) begin
                        state <= ASP_CMP;
                    end
                end
                ASP_CMP: begin
                    if (cmp_cnt == 5'(asp_pkg::PW_WORDS)) begin
                        state <= ASP_IDLE;
                    end
                end
                ASP_DONE: state <= ASP_IDLE;
                default: state <= ASP_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            word_idx <= 8'h00;
            sel_master <= 1'b0;
        end else if (state == ASP_IDLE) begin
            word_idx <= 8'h00;
        end else if (state == ASP_XFER && data_valid) begin
            word_idx <= word_idx + 8'h01;
            if (word_idx == 8'h00) begin
                sel_master <= data_word[asp_pkg::CTRL_SEL_BIT];
            end
        end
    end

    // Read is registered, so the verdict for address n shows one cycle later
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmp_idx <= 4'h0;
            cmp_cnt <= 5'h00;
            cmp_live <= 1'b0;
            mismatch <= 1'b0;
        end else if (state == ASP_CMP) begin
            cmp_idx <= cmp_idx + 4'h1;
            cmp_cnt <= cmp_cnt + 5'h01;
            cmp_live <= 1'b1;
            mismatch <= fail;
        end else begin
            cmp_idx <= 4'h0;
            cmp_cnt <= 5'h00;
            cmp_live <= 1'b0;
            mismatch <= 1'b0;
        end
    end

    // Arming survives only to the very next command
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (cmd_valid && state == ASP_IDLE) begin
            armed <= (cmd_code == asp_pkg::OP_ERASE_ARM);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status <= asp_pkg::STATUS_RESET;
            error <= asp_pkg::ERROR_RESET;
            cmd_done <= 1'b0;
            lock_off <= 1'b0;
            erase_go <= 1'b0;
        end else begin
            cmd_done <= 1'b0;
            lock_off <= 1'b0;
            erase_go <= 1'b0;
            if (state == ASP_IDLE && cmd_valid) begin
                status <= 8'h00;
                status[asp_pkg::ST_BSY] <= 1'b1;
                error <= 8'h00;
                if (cmd_code == asp_pkg::OP_DISABLE_PW) begin
                    status <= 8'h00;
                    status[asp_pkg::ST_DRQ] <= 1'b1;
                end else if (cmd_code == asp_pkg::OP_ERASE_UNIT && !armed) begin
                    status[asp_pkg::ST_ERR] <= 1'b1;
                    error[asp_pkg::ER_ABRT] <= 1'b1;
                end else if (cmd_code == asp_pkg::OP_ERASE_UNIT) begin
                    erase_go <= 1'b1;
                end
            end else if (state == ASP_XFER && data_valid && word_idx == asp_pkg::LAST_WORD) begin
                status <= 8'h00;
                status[asp_pkg::ST_BSY] <= 1'b1;
            end else if (state == ASP_CMP && cmp_cnt == 5'(asp_pkg::PW_WORDS)) begin
                status <= 8'h00;
                status[asp_pkg::ST_RDY] <= 1'b1;
                cmd_done <= 1'b1;
                // Master left untouched; only the lock is released
                if ((!security_on && !sel_master) || fail) begin
                    status[asp_pkg::ST_ERR] <= 1'b1;
                    error[asp_pkg::ER_ABRT] <= 1'b1;
                end else begin
                    lock_off <= 1'b1;
                end
            end else if (state == ASP_DONE) begin
                status[asp_pkg::ST_BSY] <= 1'b0;
                status[asp_pkg::ST_RDY] <= 1'b1;
                cmd_done <= 1'b1;
            end
        end
    end

    property p_arm_nodata;
        @(posedge core_clk) disable iff (rst)
        (state == ASP_IDLE && cmd_valid && cmd_code == asp_pkg::OP_ERASE_ARM)
            |=> !status[asp_pkg::ST_DRQ] ##1 (cmd_done && !status[asp_pkg::ST_BSY]);
    endproperty
    a_arm_nodata: assert property (p_arm_nodata) else $error("arm moved data");

    property p_unarmed_abort;
        @(posedge core_clk) disable iff (rst)
        (state == ASP_IDLE && cmd_valid && cmd_code == asp_pkg::OP_ERASE_UNIT && !armed)
            |=> ##1 (error == 8'h04 && status[asp_pkg::ST_ERR] && !erase_go);
    endproperty
    a_unarmed_abort: assert property (p_unarmed_abort) else $error("erase not aborted");

    property p_drq;
        @(posedge core_clk) disable iff (rst)
        (state == ASP_IDLE && cmd_valid && cmd_code == asp_pkg::OP_DISABLE_PW)
            |=> status[asp_pkg::ST_DRQ] && !status[asp_pkg::ST_BSY];
    endproperty
    a_drq: assert property (p_drq) else $error("no data request");

    property p_no_early_unlock;
        @(posedge core_clk) disable iff (rst)
        (state == ASP_XFER) |-> !lock_off && !cmd_done;
    endproperty
    a_no_early_unlock: assert property (p_no_early_unlock) else $error("early verdict");

    property p_user_off_abort;
        @(posedge core_clk) disable iff (rst)
        (cmd_done && !security_on && !sel_master && $past(state) == ASP_CMP)
            |-> error[asp_pkg::ER_ABRT] && !lock_off;
    endproperty
    a_user_off_abort: assert property (p_user_off_abort) else $error("no abort");

    property p_abort_bits;
        @(posedge core_clk) disable iff (rst)
        error[asp_pkg::ER_ABRT] |-> status[asp_pkg::ST_ERR] && error == 8'h04;
    endproperty
    a_abort_bits: assert property (p_abort_bits) else $error("bad error bits");

    property p_done_idle;
        @(posedge core_clk) disable iff (rst)
        cmd_done |-> !status[asp_pkg::ST_BSY] && state == ASP_IDLE;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("busy at done");

    property p_unlock_ok;
        @(posedge core_clk) disable iff (rst)
        lock_off |-> cmd_done && !error[asp_pkg::ER_ABRT];
    endproperty
    a_unlock_ok: assert property (p_unlock_ok) else $error("unlock with error");
endmodule : asp_cmd

// File: testbench/asp_host_model.sv
/* Host side model: issues one command, then one sector when asked.
   Assumes the block samples its inputs on rising core_clk edges. */
module asp_host_model (
    input wire logic core_clk,
    input wire logic [7:0] status,
    input wire logic cmd_done,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic data_valid,
    output logic [15:0] data_word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        data_valid = 1'b0;
        data_word = 16'h0000;
    end

    // Commands only start once the previous one is done or 100 cycles have passed without cmd_done
    task automatic run(input logic [7:0] code, input logic sel, input logic [255:0] pw,
        output logic [7:0] st1);
        int n;
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        cmd_code = ~code;
        st1 = status;
        if (status[3] === 1'b1) begin
            for (int i = 0; i < 256; i++) begin
                data_valid = 1'b1;
                if (i == 0)
                    data_word = {15'h2d2d, sel};
                else if (i <= 16)
                    data_word = pw[16*(i-1) +: 16];
                else
                    data_word = 16'ha5a5 ^ 16'(i);
                @(negedge core_clk);
            end
            data_valid = 1'b0;
            // Released bus shows no stale word
            data_word = ~data_word;
        end
        n = 0;
        while (cmd_done !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
    endtask : run
endmodule : asp_host_model

// File: testbench/tb_ata_security_password_commands.sv
/* Self-checking bench for the security password command block.
   Assumes the host model is compiled alongside and drives the command port. */
module tb_ata_security_password_commands;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [255:0] UPW =
        256'h00112233445566778899aabbccddeeff0f1e2d3c4b5a69788796a5b4c3d2e1f0;
    // Format-unit opcode stand-in; the block treats it as any other code
    localparam logic [7:0] FMT_CODE = 8'h00;
    logic core_clk, rst, security_on, cmd_valid, data_valid, cmd_done, lock_off, erase_go;
    logic [7:0] cmd_code, status, error;
    logic [15:0] data_word;
    logic [255:0] user_pw, master_pw;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int go_cnt = 0;
    int lk_cnt = 0;
    int dn_cnt = 0;

    always #12.5ns core_clk = ~core_clk;

    asp_cmd asp_cmd_inst (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .data_valid(data_valid), .data_word(data_word),
        .user_pw(user_pw), .master_pw(master_pw), .security_on(security_on),
        .status(status), .error(error), .cmd_done(cmd_done), .lock_off(lock_off),
        .erase_go(erase_go));
    asp_host_model asp_host_model_inst (.core_clk(core_clk), .status(status),
        .cmd_done(cmd_done), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .data_valid(data_valid), .data_word(data_word));

    // Pulses counted mid-cycle, where they are settled
    always @(negedge core_clk) begin
        cycles++;
        if (erase_go === 1'b1)
            go_cnt++;
        if (cmd_done === 1'b1)
            dn_cnt++;
        if (lock_off === 1'b1)
            lk_cnt++;
        if (cycles == 8000) begin
            err_count++;
            print_verdict();
        end
    end

    task print_verdict;
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic do_cmd(input logic [7:0] code, input logic sel, input logic [255:0] pw,
        input logic ab, input int e_go, input int e_lk);
        int g0;
        int l0;
        int d0;
        logic [7:0] st1;
        g0 = go_cnt;
        l0 = lk_cnt;
        d0 = dn_cnt;
        asp_host_model_inst.run(code, sel, pw, st1);
        check({6'h00, st1[7], st1[3]}, (code == asp_pkg::OP_DISABLE_PW) ? 8'h01 : 8'h02);
        check(status, ab ? 8'h41 : 8'h40);
        check(error, ab ? 8'h04 : 8'h00);
        @(negedge core_clk);
        check(8'(go_cnt - g0), 8'(e_go));
        check(8'(lk_cnt - l0), 8'(e_lk));
        check(8'(dn_cnt - d0), 8'h01);
    endtask : do_cmd

    task sc_erase_armed;
        do_cmd(asp_pkg::OP_ERASE_ARM, 1'b0, UPW, 1'b0, 0, 0);
        do_cmd(asp_pkg::OP_ERASE_UNIT, 1'b0, UPW, 1'b0, 1, 0);
        do_cmd(asp_pkg::OP_ERASE_ARM, 1'b0, UPW, 1'b0, 0, 0);
        do_cmd(FMT_CODE, 1'b0, UPW, 1'b0, 0, 0);
        // Arming was spent on the format command
        do_cmd(asp_pkg::OP_ERASE_UNIT, 1'b0, UPW, 1'b1, 0, 0);
    endtask : sc_erase_armed

    task sc_erase_unarmed;
        do_cmd(asp_pkg::OP_ERASE_UNIT, 1'b0, UPW, 1'b1, 0, 0);
        do_cmd(asp_pkg::OP_ERASE_ARM, 1'b0, UPW, 1'b0, 0, 0);
        do_cmd(8'h00, 1'b0, UPW, 1'b0, 0, 0);
        do_cmd(asp_pkg::OP_ERASE_UNIT, 1'b0, UPW, 1'b1, 0, 0);
        do_cmd(asp_pkg::OP_ERASE_ARM, 1'b0, UPW, 1'b0, 0, 0);
        do_cmd(asp_pkg::OP_DISABLE_PW, 1'b1, ~UPW, 1'b0, 0, 1);
        do_cmd(asp_pkg::OP_ERASE_UNIT, 1'b0, UPW, 1'b1, 0, 0);
    endtask : sc_erase_unarmed

    task sc_disable_user;
        security_on = 1'b1;
        do_cmd(asp_pkg::OP_DISABLE_PW, 1'b0, UPW, 1'b0, 0, 1);
        do_cmd(asp_pkg::OP_DISABLE_PW, 1'b0, UPW ^ (256'h1 << 255), 1'b1, 0, 0);
        do_cmd(asp_pkg::OP_DISABLE_PW, 1'b0, UPW ^ 256'h1, 1'b1, 0, 0);
        do_cmd(asp_pkg::OP_DISABLE_PW, 1'b1, UPW, 1'b1, 0, 0);
    endtask : sc_disable_user

    task sc_disable_master;
        security_on = 1'b1;
        do_cmd(asp_pkg::OP_DISABLE_PW, 1'b1, ~UPW, 1'b0, 0, 1);
        do_cmd(asp_pkg::OP_DISABLE_PW, 1'b0, ~UPW, 1'b1, 0, 0);
        // Master still accepted after a successful disable
        do_cmd(asp_pkg::OP_DISABLE_PW, 1'b1, ~UPW, 1'b0, 0, 1);
    endtask : sc_disable_master

    task sc_security_off;
        security_on = 1'b0;
        do_cmd(asp_pkg::OP_DISABLE_PW, 1'b0, UPW, 1'b1, 0, 0);
        do_cmd(asp_pkg::OP_DISABLE_PW, 1'b1, ~UPW, 1'b0, 0, 1);
    endtask : sc_security_off

    task sc_reset_mid;
        do_cmd(asp_pkg::OP_ERASE_UNIT, 1'b0, UPW, 1'b1, 0, 0);
        rst = 1'b1;
        @(negedge core_clk);
        check(status, asp_pkg::STATUS_RESET);
        check(error, asp_pkg::ERROR_RESET);
        rst = 1'b0;
        do_cmd(asp_pkg::OP_ERASE_ARM, 1'b0, UPW, 1'b0, 0, 0);
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        // Arming must not survive a reset
        do_cmd(asp_pkg::OP_ERASE_UNIT, 1'b0, UPW, 1'b1, 0, 0);
    endtask : sc_reset_mid

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        security_on = 1'b1;
        user_pw = UPW;
        master_pw = ~UPW;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        sc_erase_armed();
        sc_erase_unarmed();
        sc_disable_user();
        sc_disable_master();
        sc_security_off();
        sc_reset_mid();
        print_verdict();
    end
endmodule : tb_ata_security_password_commands
